//--- hdl/bsam_top.sv
// Purpose: Address map for flash self-programming
// Assumes: CPU gives pointer and command on the same clock
// Notes: Fuse lines pass two flops; every output is registered
// Function
// - Small variant counter is 12 bits
// - Large variant counter is 13 bits
// - Small boot size selects section start
// - Large boot size selects section start
// - Small readable and halting sections fixed
// - Large readable and halting sections fixed
// - Small page is 32 words
// - Large page is 64 words
// - Pointer bit n+1 maps to counter n
// - Page number from upper pointer field
// - Buffer word from low pointer field
// - Upper pointer bits ignored
// - Pointer bit zero selects read byte
// - Busy readable section blocks its reads
// - Halting section write stalls the CPU
`include "bsam_map.svh"
module bsam_top #(
   parameter bit LARGE = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] boot_size_fuse,
   input wire logic [15:0] pointer,
   input wire bsam_pkg::bsam_cmd_e cmd,
   input wire logic cmd_valid,
   input wire logic prog_done,
   input wire logic section_reenable,
   input wire logic page_load,
   input wire logic read_req,
   output logic [12:0] prog_word_addr,
   output logic [6:0] page_number_field,
   output logic [5:0] within_page_word_field,
   output logic [12:0] read_word_addr,
   output logic read_byte_hi,
   output logic read_blocked,
   output logic cpu_stall,
   output logic section_busy_flag,
   output logic [12:0] boot_start,
   output logic [1:0] boot_size_q
);
   localparam int PC_W = LARGE ? `BSAM_LARGE_PC_W : `BSAM_SMALL_PC_W;
   localparam int PAGE_W = LARGE ? `BSAM_LARGE_PAGE_W : `BSAM_SMALL_PAGE_W;
   localparam int counter_top_bit = PC_W - 1;
   localparam int page_word_top_bit = PAGE_W - 1;
   localparam int pointer_counter_top_bit = counter_top_bit + 1;
   localparam int pointer_page_word_top_bit = page_word_top_bit + 1;

   // Page field ports are fixed at seven bits
   if (PC_W - PAGE_W != 7) begin : g_bad_width
      $error("bsam_top: page field must be 7 bits");
   end

   logic [12:0] ptr_word;
   logic [12:0] rd_word;
   logic [1:0] boot_size_d;
   logic boot_taken_q;
   logic boot_taken_d;
   logic [1:0] fuse_meta_q;
   logic [1:0] fuse_sync_q;
   bsam_pkg::bsam_state_e state_q;
   bsam_pkg::bsam_state_e state_d;
   logic halt_op_q;
   logic halt_op_d;
   logic busy_q;
   logic busy_d;
   logic [12:0] prog_word_d;
   logic [6:0] page_d;
   logic [5:0] word_d;
   logic [12:0] read_word_d;
   logic read_hi_d;
   logic read_blocked_d;
   logic stall_d;

   bsam_sect_if prog_sect();
   bsam_sect_if read_sect();

   // Pointer bit n+1 to counter bit n, upper bits dropped
   always_comb begin
      ptr_word = '0;
      ptr_word[counter_top_bit:0] =
         pointer[pointer_counter_top_bit:1];
      rd_word = ptr_word;
   end

   bsam_decode #(.LARGE(LARGE)) u_prog_dec (
      .word_addr(ptr_word),
      .boot_size_select(boot_size_q),
      .sect(prog_sect)
   );

   bsam_decode #(.LARGE(LARGE)) u_read_dec (
      .word_addr(rd_word),
      .boot_size_select(boot_size_q),
      .sect(read_sect)
   );

   // Fuse lines come from outside the clock domain
   always_ff @(posedge clk) begin
      fuse_meta_q <= boot_size_fuse;
      fuse_sync_q <= fuse_meta_q;
   end

   // Fuse captured once after reset release
   always_comb begin
      boot_taken_d = 1'b1;
      boot_size_d = boot_taken_q ? boot_size_q : fuse_sync_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         boot_taken_q <= 1'b0;
         boot_size_q <= `BSAM_BOOT_SIZE_RESET;
      end else begin
         boot_taken_q <= boot_taken_d;
         boot_size_q <= boot_size_d;
      end
   end

   // Programming sequence and section busy tracking
   always_comb begin
      state_d = state_q;
      halt_op_d = halt_op_q;
      busy_d = busy_q;
      if (page_load || (section_reenable && state_q == bsam_pkg::BSAM_IDLE))
         busy_d = 1'b0;
      unique case (state_q)
         bsam_pkg::BSAM_IDLE: begin
            if (cmd_valid && boot_taken_q &&
                  (cmd == bsam_pkg::BSAM_CMD_ERASE ||
                   cmd == bsam_pkg::BSAM_CMD_WRITE)) begin
               state_d = bsam_pkg::BSAM_BUSY;
               halt_op_d = prog_sect.in_halt;
               if (!prog_sect.in_halt)
                  busy_d = 1'b1;
            end
         end
         bsam_pkg::BSAM_BUSY: begin
            if (prog_done) begin
               state_d = bsam_pkg::BSAM_IDLE;
               halt_op_d = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= bsam_pkg::BSAM_IDLE;
         halt_op_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         halt_op_q <= halt_op_d;
         busy_q <= busy_d;
      end
   end

   // Address fields registered for the flash array
   always_comb begin
      prog_word_d = prog_word_addr;
      page_d = page_number_field;
      word_d = within_page_word_field;
      if (cmd_valid && state_q == bsam_pkg::BSAM_IDLE) begin
         prog_word_d = ptr_word;
         // Page from pointer upper field
         page_d = ptr_word[counter_top_bit:page_word_top_bit + 1];
         word_d = '0;
         // Buffer word from low field
         if (cmd == bsam_pkg::BSAM_CMD_FILL)
            word_d[page_word_top_bit:0] =
               pointer[pointer_page_word_top_bit:1];
      end
   end

   // Read path: byte select and blocking
   always_comb begin
      read_word_d = read_word_addr;
      read_hi_d = read_byte_hi;
      read_blocked_d = 1'b0;
      if (read_req) begin
         read_word_d = rd_word;
         read_hi_d = pointer[0];
         read_blocked_d = busy_d && !read_sect.in_halt;
      end
      // Stall for halting section operation
      stall_d = state_d == bsam_pkg::BSAM_BUSY && halt_op_d;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prog_word_addr <= '0;
         page_number_field <= '0;
         within_page_word_field <= '0;
         read_word_addr <= '0;
         read_byte_hi <= 1'b0;
         read_blocked <= 1'b0;
         cpu_stall <= 1'b0;
         section_busy_flag <= 1'b0;
         boot_start <= '0;
      end else begin
         prog_word_addr <= prog_word_d;
         page_number_field <= page_d;
         within_page_word_field <= word_d;
         read_word_addr <= read_word_d;
         read_byte_hi <= read_hi_d;
         read_blocked <= read_blocked_d;
         cpu_stall <= stall_d;
         section_busy_flag <= busy_d;
         boot_start <= read_sect.boot_start;
      end
   end
endmodule

//--- hdl/bsam_map.svh
// Purpose: Constants for the boot section address map
// Assumes: Word addresses, pointer is a byte address
// Notes: Two variants, selected by a top parameter
`ifndef BSAM_MAP_SVH
`define BSAM_MAP_SVH

`define BSAM_SMALL_PC_W 12
`define BSAM_LARGE_PC_W 13
`define BSAM_SMALL_PAGE_W 5
`define BSAM_LARGE_PAGE_W 6
`define BSAM_SMALL_HALT_START 13'h0c00
`define BSAM_LARGE_HALT_START 13'h1c00
`define BSAM_BOOT_WORDS_11 13'h0080
`define BSAM_BOOT_WORDS_10 13'h0100
`define BSAM_BOOT_WORDS_01 13'h0200
`define BSAM_BOOT_WORDS_00 13'h0400
`define BSAM_PTR_W 16
`define BSAM_BOOT_SIZE_RESET 2'h0

`endif

//--- hdl/bsam_pkg.sv
// Purpose: Types for the boot section address map
// Assumes: Nothing beyond the map header
// Notes: Command kinds presented by the CPU
package bsam_pkg;
   typedef enum logic [1:0] {
      BSAM_CMD_NONE,
      BSAM_CMD_FILL,
      BSAM_CMD_ERASE,
      BSAM_CMD_WRITE
   } bsam_cmd_e;
   typedef enum {
      BSAM_IDLE,
      BSAM_BUSY
   } bsam_state_e;
endpackage

//--- hdl/bsam_sect_if.sv
// Purpose: Carries a decoded word address between blocks
// Assumes: Single clock
// Notes: Decoder drives, top reads
interface bsam_sect_if;
   logic [12:0] word_addr;
   logic in_boot;
   logic in_halt;
   logic [12:0] boot_start;
   modport decoder (output word_addr, output in_boot, output in_halt,
      output boot_start);
   modport user (input word_addr, input in_boot, input in_halt,
      input boot_start);
endinterface

//--- hdl/bsam_decode.sv
// Purpose: Combinational section decode of one word address
// Assumes: Boot size field already held stable
// Notes: Address is zero-extended to 13 bits in the small variant
`include "bsam_map.svh"
module bsam_decode #(
   parameter bit LARGE = 1'b0
) (
   input wire logic [12:0] word_addr,
   input wire logic [1:0] boot_size_select,
   bsam_sect_if.decoder sect
);
   localparam logic [12:0] TOP_END = LARGE ? 13'h1fff : 13'h0fff;
   localparam logic [12:0] HALT_START = LARGE ?
      `BSAM_LARGE_HALT_START : `BSAM_SMALL_HALT_START;
   logic [12:0] boot_words;

   always_comb begin
      unique case (boot_size_select)
         2'h3: boot_words = `BSAM_BOOT_WORDS_11;
         2'h2: boot_words = `BSAM_BOOT_WORDS_10;
         2'h1: boot_words = `BSAM_BOOT_WORDS_01;
         2'h0: boot_words = `BSAM_BOOT_WORDS_00;
      endcase
   end

   // Boot section sits at top of flash
   assign sect.boot_start = TOP_END - boot_words + 13'h0001;
   assign sect.word_addr = word_addr;
   assign sect.in_boot = word_addr >= sect.boot_start;
   // Fixed split, independent of boot size
   assign sect.in_halt = word_addr >= HALT_START;
endmodule

//--- tb/bsam_flash_model.sv
// Purpose: Flash timing partner for the address map bench
// Assumes: start marks a taken erase or write
// Notes: dly picks a prompt or a slow finish
module bsam_flash_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [7:0] dly,
   output logic prog_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) cnt_q <= 8'h0;
      else if (start && cnt_q == 8'h0) cnt_q <= dly;
      else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
      prog_done <= rst_n && cnt_q == 8'h1;
   end
endmodule

//--- tb/bsam_top_sva.sv
// Purpose: Checker for the boot section address map
// Assumes: Bound to bsam_top
// Notes: Pending operation tracked in op_q
module bsam_chk #(
   parameter bit LARGE = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] pointer,
   input wire bsam_pkg::bsam_cmd_e cmd,
   input wire logic cmd_valid,
   input wire logic prog_done,
   input wire logic read_req,
   input wire logic [12:0] prog_word_addr,
   input wire logic [6:0] page_number_field,
   input wire logic [5:0] within_page_word_field,
   input wire logic [12:0] read_word_addr,
   input wire logic read_byte_hi,
   input wire logic read_blocked,
   input wire logic cpu_stall,
   input wire logic section_busy_flag,
   input wire logic [12:0] boot_start,
   input wire logic [1:0] boot_size_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic op_q, take, prog;
   logic [12:0] wa, hs;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   assign take = cmd_valid && !op_q;
   assign prog = cmd >= bsam_pkg::BSAM_CMD_ERASE;
   assign wa = LARGE ? pointer[13:1] : {1'b0, pointer[12:1]};
   assign hs = LARGE ? 13'h1c00 : 13'h0c00;
   always_ff @(posedge clk)
      if (!rst_n || prog_done) op_q <= 1'b0;
      else if (take && prog) op_q <= 1'b1;
   a_word_addr: assert property (
      take |=> prog_word_addr == $past(wa)) else $error("word addr");
   a_page_field: assert property (take |=> page_number_field ==
      $past(LARGE ? pointer[13:7] : pointer[12:6])) else $error("page");
   a_fill_word: assert property (
      take && cmd == bsam_pkg::BSAM_CMD_FILL |=> within_page_word_field ==
      $past(LARGE ? pointer[6:1] : {1'b0, pointer[5:1]})) else $error("wf");
   a_read_map: assert property (read_req |=> read_byte_hi ==
      $past(pointer[0]) && read_word_addr == $past(wa)) else $error("rd");
   a_halt_stall: assert property (
      take && prog && wa >= hs |=> cpu_stall) else $error("no stall");
   a_stall_hold: assert property (
      cpu_stall && !prog_done |=> cpu_stall) else $error("stall dropped");
   a_rww_busy: assert property (take && prog && wa < hs |=>
      section_busy_flag && !cpu_stall) else $error("busy");
   a_read_block: assert property (
      read_req && section_busy_flag && wa < hs |=> read_blocked)
      else $error("not blocked");
   a_boot_start: assert property (
      $past(rst_n) && $stable(boot_size_q) |=> boot_start ==
      (LARGE ? 13'h1fff : 13'h0fff) - (13'h0080 << (2'h3 - boot_size_q))
      + 13'h0001) else $error("boot start");
endmodule

bind bsam_top bsam_chk #(.LARGE(LARGE)) i_chk(.*);

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the address map
// Assumes: Small and large variants see the same stimulus
// Notes: Flash completion comes from bsam_flash_model
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, cv = 0, rd = 0, ren = 0, pl = 0, done;
   logic [1:0] fuse = 2'h3, bsq;
   logic [15:0] ptr = 16'h0;
   bsam_pkg::bsam_cmd_e cmd = bsam_pkg::BSAM_CMD_NONE;
   logic rbh, blk, stall, busy;
   logic [12:0] pwa, rwa, bst;
   logic [6:0] pg;
   logic [5:0] wf;
   logic [7:0] dly = 8'h28;
   logic rbh_l, blk_l, stall_l, busy_l;
   logic [1:0] bsq_l;
   logic [12:0] pwa_l, rwa_l, bst_l;
   logic [6:0] pg_l;
   logic [5:0] wf_l;
   int bad_count = 0, compares = 0, cyc = 0;
   always #20 clk = ~clk;
   bsam_top #(.LARGE(1'b0)) i_dut(.clk(clk), .rst_n(rst_n),
      .boot_size_fuse(fuse), .pointer(ptr), .cmd(cmd), .cmd_valid(cv),
      .prog_done(done), .section_reenable(ren), .page_load(pl),
      .read_req(rd), .prog_word_addr(pwa), .page_number_field(pg),
      .within_page_word_field(wf), .read_word_addr(rwa),
      .read_byte_hi(rbh), .read_blocked(blk), .cpu_stall(stall),
      .section_busy_flag(busy), .boot_start(bst), .boot_size_q(bsq));
   bsam_flash_model i_flash(.clk(clk), .rst_n(rst_n), .dly(dly),
      .start(cv && cmd >= bsam_pkg::BSAM_CMD_ERASE), .prog_done(done));
   bsam_top #(.LARGE(1'b1)) i_dut_lg(.clk(clk), .rst_n(rst_n),
      .boot_size_fuse(fuse), .pointer(ptr), .cmd(cmd), .cmd_valid(cv),
      .prog_done(done), .section_reenable(ren), .page_load(pl),
      .read_req(rd), .prog_word_addr(pwa_l), .page_number_field(pg_l),
      .within_page_word_field(wf_l), .read_word_addr(rwa_l),
      .read_byte_hi(rbh_l), .read_blocked(blk_l), .cpu_stall(stall_l),
      .section_busy_flag(busy_l), .boot_start(bst_l), .boot_size_q(bsq_l));
   function automatic logic [12:0] boot_exp(input bit lg, input int sz);
      return (lg ? 13'h1fff : 13'h0fff) - (13'h0080 << (3 - sz)) + 13'h0001;
   endfunction
   task automatic chk(input string n, input logic [12:0] e, g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic issue(bsam_pkg::bsam_cmd_e c, logic [15:0] p, bit r);
      @(posedge clk);
      cmd <= c;
      ptr <= p;
      if (r) rd <= 1'b1;
      else cv <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      cv <= 1'b0;
      @(negedge clk);
   endtask
   task automatic pulse(input bit load);
      @(posedge clk);
      if (load) pl <= 1'b1;
      else ren <= 1'b1;
      @(posedge clk);
      pl <= 1'b0;
      ren <= 1'b0;
      @(negedge clk);
   endtask
   task automatic waitfor(ref logic s, input logic v);
      for (int k = 0; k < 200 && s !== v; k++) @(negedge clk);
   endtask
   task automatic tally_and_finish;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) rst_n <= 1'b0;
         fuse <= 2'(i);
         repeat (6) @(posedge clk);
         rst_n <= 1'b1;
         repeat (3) @(negedge clk);
         chk("boot", 13'h1000 - (13'h0080 << (3 - i)), bst);
         chk("fuse", 13'(i), 13'(bsq));
         chk("boot_lg", boot_exp(1'b1, i), bst_l);
         chk("fuse_lg", 13'(i), 13'(bsq_l));
      end
      $display("test boot_size done");
      issue(bsam_pkg::BSAM_CMD_FILL, 16'hf7fe, 0);
      chk("waddr", 13'h0bff, pwa);
      chk("page", 13'h005f, 13'(pg));
      chk("wfield", 13'h001f, 13'(wf));
      chk("waddr_lg", 13'h1bff, pwa_l);
      chk("page_lg", 13'h006f, 13'(pg_l));
      chk("wfield_lg", 13'h003f, 13'(wf_l));
      issue(bsam_pkg::BSAM_CMD_NONE, 16'hf7ff, 1);
      chk("raddr", 13'h0bff, rwa);
      chk("byte", 13'h1, 13'(rbh));
      chk("blk", 13'h0, 13'(blk));
      chk("raddr_lg", 13'h1bff, rwa_l);
      chk("byte_lg", 13'h1, 13'(rbh_l));
      chk("blk_lg", 13'h0, 13'(blk_l));
      $display("test fill_read done");
      issue(bsam_pkg::BSAM_CMD_ERASE, 16'h17c0, 0);
      chk("busy", 13'h2, 13'({busy, stall}));
      chk("busy_lg", 13'h2, 13'({busy_l, stall_l}));
      issue(bsam_pkg::BSAM_CMD_NONE, 16'h0001, 1);
      chk("blk", 13'h1, 13'(blk));
      chk("blk_lg", 13'h1, 13'(blk_l));
      waitfor(done, 1'b1);
      pulse(1'b0);
      chk("reen", 13'h0, 13'(busy));
      chk("reen_lg", 13'h0, 13'(busy_l));
      issue(bsam_pkg::BSAM_CMD_ERASE, 16'h0040, 0);
      pulse(1'b1);
      chk("pload", 13'h0, 13'(busy));
      chk("pload_lg", 13'h0, 13'(busy_l));
      waitfor(done, 1'b1);
      $display("test rww_erase done");
      dly <= 8'h02;
      issue(bsam_pkg::BSAM_CMD_WRITE, 16'h3800, 0);
      chk("stall", 13'h1, 13'(stall));
      chk("page", 13'h0060, 13'(pg));
      chk("waddr", 13'h0c00, pwa);
      chk("stall_lg", 13'h1, 13'(stall_l));
      chk("page_lg", 13'h0070, 13'(pg_l));
      chk("waddr_lg", 13'h1c00, pwa_l);
      waitfor(stall, 1'b0);
      chk("stall", 13'h0, 13'(stall));
      chk("stall_lg", 13'h0, 13'(stall_l));
      $display("test halt_write done");
      tally_and_finish();
   end
endmodule
